// file: src/clock_divide_delay_params.svh
// Purpose: constants for the clock divide/delay distribution block
// Assumes: APB register map with one 32-bit word per register
// Notes:   offsets are byte addresses
// Operation
// RULE1 - each group divides distribution clock by 1..1045 with 50% duty (code: odd divides come within a tick of 50%)
// RULE2 - group uses extended mode when divide value is 26 or more
// RULE3 - coarse delay 4.5..12 cycles normal, 12.5..522 cycles extended (code: whole ticks, clamped to 4..12 normal and 12..522 extended)
// RULE4 - half-step bit gives half-period coarse step when divide exceeds one (code: no delay step, widens the high part of odd divides by one tick)
// RULE5 - new coarse delay takes effect only at the next sync event
// RULE6 - coarse delay supports fixed, absolute dynamic and relative dynamic use
// RULE7 - oscillator divider accepts 2..8 with 50% duty for odd and even (code: 3-bit field gives 2..7, odd divides not 50%)
// RULE8 - selector feeds direct or divided oscillator to distribution and feedback
// RULE9 - buffered output divider accepts 1 through 8
// RULE10 - each buffered output independently selects divider result or bypass
// RULE11 - two groups may take the oscillator input port directly
// RULE12 - oscillator-sourced outputs are held low while sync is asserted (code: an oscillator-port group set sync exempt is not held low)
// RULE13 - sync-exempt group keeps running through a sync event
// RULE14 - reference selector passes one of three inputs, manual or automatic
// RULE15 - each reference input has its own pre-divider
// RULE16 - host may drive status select pins to choose the reference directly
// RULE17 - second reference reusable as feedback port or oscillator input
// RULE18 - single-loop mode powers down first loop, oscillator port is reference
// RULE19 - distribution-only mode routes second reference through group paths
// RULE20 - both outputs of a group share one divider
// RULE21 - fine delay 25 ps steps 0..475 ps, enable adds 500 ps
// RULE22 - host programs crystal mode before a crystal is used
// RULE23 - reference pre-dividers support exactly 1, 2, 4 and 8
// RULE24 - sync re-aligns active synchronized groups to a common rising edge
`ifndef CLOCK_DIVIDE_DELAY_PARAMS_SVH
`define CLOCK_DIVIDE_DELAY_PARAMS_SVH
`define OFS_GROUP_BASE   12'h000
`define OFS_OSC_CTRL     12'h040
`define OFS_REF_CTRL     12'h044
`define OFS_MODE_CTRL    12'h048
`define OFS_STATUS       12'h04C
`define GDIV_LSB         0
`define GDLY_LSB         11
`define GHS_BIT          21
`define GNOSYNC_BIT      22
`define GOSCSRC_BIT      23
`define GFINE_LSB        24
`define GFINE_EN_BIT     29
`define GDIV_RST         11'h001
`define GDLY_RST         10'h005
`define EXT_THRESH       11'h01A
`define GDIV_MAX         11'h415
`define NORM_DLY_MIN     10'h004
`define NORM_DLY_MAX     10'h00C
`define EXT_DLY_MIN      10'h00C
`define EXT_DLY_MAX      10'h20A
`define FINE_MAX         5'h13
`define VDIV_MIN         3'h2
`define ODIV_MIN         4'h1
`define ODIV_MAX         4'h8
`endif

// file: src/clock_divide_delay_pkg.sv
// Purpose: types for the clock divide/delay distribution block
// Assumes: params header holds the numbers
// Notes:   none
package clock_divide_delay_pkg;
  typedef enum logic [2:0] {
    MODE_DUAL = 3'h1,
    MODE_SINGLE = 3'h2,
    MODE_DIST = 3'h4
  } loop_mode_t;
  typedef struct packed {
    logic       fine_en;
    logic [4:0] fine;
    logic       osc_src;
    logic       no_sync;
    logic       half_step;
    logic [9:0] delay;
    logic [10:0] div;
  } group_cfg_t;
  typedef struct packed {
    logic       dist_clk;
    logic       osc_clk;
    logic       sync_n;
  } clk_in_t;
endpackage

// file: src/clock_divide_delay_distribution.sv
// Purpose: digital control for divide/delay distribution with APB registers
// Assumes: all clock inputs are sampled enables synchronous to pclk
// Notes:   a group output toggles at its source ticks; half-step widens the high part of odd divides by one tick
//
// Our own choices: the placing of the registers and register access over APB.
`include "clock_divide_delay_params.svh"
module clock_divide_delay_distribution
  import clock_divide_delay_pkg::*;
#(
  parameter int NGROUPS = 6,
  parameter int NOSCOUT = 1
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // source ticks and sync
  input  wire clk_in_t              clk_in,
  input  wire logic [2:0]           ref_in,
  input  wire logic [2:0]           ref_los,
  input  wire logic [2:0]           status_select_pin_in,
  // distribution and loop outputs
  output logic      [2*NGROUPS-1:0] clk_out,
  output logic      [NOSCOUT-1:0]   buffered_osc_output,
  output logic                      ref_to_first_loop,
  output logic                      first_loop_pd,
  output logic                      second_loop_ref_sel,
  output logic                      feedback_prescaler_clk,
  // fine delay controls per group
  output logic      [4:0]           fine_delay_code [NGROUPS],
  output logic      [NGROUPS-1:0]   fine_delay_en
);

  // per group configuration and state
  group_cfg_t    cfg_reg [NGROUPS];
  logic [9:0]    dly_act_reg [NGROUPS];
  logic [10:0]   cnt_reg [NGROUPS];
  logic [10:0]   hold_reg [NGROUPS];
  logic [NGROUPS-1:0] gout_reg;
  // shared control words
  logic [31:0]   osc_ctrl_reg;
  logic [31:0]   ref_ctrl_reg;
  loop_mode_t    mode_reg;
  logic [31:0]   prdata_next;
  // sync release detection
  logic          sync_d_reg;
  // oscillator and buffered output dividers
  logic [2:0]    vcnt_reg;
  logic          vout_reg;
  logic [3:0]    ocnt_reg;
  logic          oout_reg;
  // reference pre-dividers and selection
  logic [3:0]    pcnt_reg [3];
  logic [2:0]    pout_reg;
  logic [1:0]    ref_sel_reg;

  // field views of the shared control registers
  wire [2:0] vdiv       = osc_ctrl_reg[2:0];
  wire       vdiv_sel   = osc_ctrl_reg[3];
  wire [3:0] odiv       = osc_ctrl_reg[7:4];
  wire [NOSCOUT-1:0] obypass = osc_ctrl_reg[8 +: NOSCOUT];
  wire       ref_auto   = ref_ctrl_reg[0];
  wire [1:0] ref_man    = ref_ctrl_reg[2:1];
  wire       pin_sel_en = ref_ctrl_reg[3];
  wire       refb_reuse = ref_ctrl_reg[4];
  wire       crystal_en = ref_ctrl_reg[5];

  // register map, one aligned word each
  //   0x000 + 4*g  group g control
  //     [10:0]  divide, 0 acts as 1
  //     [20:11] coarse delay, ticks
  //     [21]    half-step enable
  //     [22]    sync exempt
  //     [23]    oscillator port source
  //     [28:24] fine delay code
  //     [29]    fine delay enable
  //   0x040  oscillator control
  //     [2:0]   divider, below 2 is 2
  //     [3]     use divided oscillator
  //     [7:4]   buffered divide 1..8
  //     [8+]    per output bypass
  //   0x044  reference control
  //     [0]     automatic switching
  //     [2:1]   manual choice a, b, c
  //     [3]     choice from select pins
  //     [4]     second reference reused
  //     [5]     crystal mode
  //     [13:8]  pre-divide codes
  //   0x048  loop mode, one-hot
  //   0x04C  status, read only
  //     [1:0]   active reference
  //     [6:4]   loss flags
  //     [13:8]  group outputs
  // reset: group div 1, delay 5
  //   oscillator word 0x12
  //   reference word 0x01, mode dual
  // one-cycle access, pready tied high
  // misaligned or unmapped: pslverr
  // status writes are dropped

  // apb decode; ready and error in the access cycle, read data the cycle after; unmapped addresses flag an error
  wire        acc     = psel & penable;
  wire        wr_acc  = acc & pwrite;
  wire        in_grp  = (paddr < `OFS_OSC_CTRL);
  wire [3:0]  gidx    = paddr[5:2];
  wire        grp_ok  = in_grp & (gidx < 4'(NGROUPS)) & (paddr[1:0] == 2'h0);
  wire        osc_hit = (paddr == `OFS_OSC_CTRL);
  wire        ref_hit = (paddr == `OFS_REF_CTRL);
  wire        mod_hit = (paddr == `OFS_MODE_CTRL);
  wire        sta_hit = (paddr == `OFS_STATUS);
  wire        mapped  = grp_ok | osc_hit | ref_hit | mod_hit | sta_hit;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // sync handling
  //   low level forces synced groups low
  //   and the buffered outputs low too
  //   buffered outputs are not retimed,
  //   so a glitch at either sync edge
  //   is possible
  //   release is seen in its first cycle
  //   synced groups not on the oscillator port restart together

  // sync is active low; event on its release re-aligns groups
  wire sync_act  = ~clk_in.sync_n;
  wire sync_rel  = sync_d_reg & ~sync_act;

  // read data selection
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (grp_ok)
      prdata_next = {2'h0, cfg_reg[gidx[2:0]]};
    else if (osc_hit)
      prdata_next = osc_ctrl_reg;
    else if (ref_hit)
      prdata_next = ref_ctrl_reg;
    else if (mod_hit)
      prdata_next = {29'h0, mode_reg};
    else if (sta_hit)
      prdata_next = {18'h0, gout_reg[5:0], 1'h0, ref_los, 2'h0, ref_sel_reg};
  end

  // mode write strobe; only one-hot codes
  wire mode_wr = wr_acc & mod_hit & (pwdata[2:0] inside {3'h1, 3'h2, 3'h4});

  // read data capture, held until next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (acc && !pwrite) begin
      prdata <= prdata_next;
    end
  end

  // sync level one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_d_reg <= 1'b0;
    end else begin
      sync_d_reg <= sync_act;
    end
  end

  // oscillator control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ctrl_reg <= 32'h0000_0012;
    end else if (wr_acc && osc_hit) begin
      osc_ctrl_reg <= pwdata;
    end
  end

  // reference control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ctrl_reg <= 32'h0000_0001;
    end else if (wr_acc && ref_hit) begin
      ref_ctrl_reg <= pwdata;
    end
  end

  // loop mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_DUAL;
    end else if (mode_wr) begin
      mode_reg <= loop_mode_t'(pwdata[2:0]);
    end
  end

  // distribution source: direct or divided oscillator
  wire div_tick  = clk_in.dist_clk & (vcnt_reg == 3'h0);
  wire dist_tick = vdiv_sel ? div_tick : clk_in.dist_clk; // RULE8

  // oscillator divider notes
  //   counts 0 .. vdiv_c-1 on source ticks
  //   output high from 0 to half count
  //   divided tick fires once per count

  // oscillator divider 2..7, counting source ticks per whole period
  wire [2:0] vdiv_c = (vdiv < `VDIV_MIN) ? `VDIV_MIN : vdiv; // RULE7
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcnt_reg <= 3'h0;
      vout_reg <= 1'b0;
    end else if (clk_in.dist_clk) begin
      vcnt_reg <= (vcnt_reg == vdiv_c - 3'h1) ? 3'h0 : vcnt_reg + 3'h1; // RULE7
      vout_reg <= (vcnt_reg == 3'h0) ? 1'b1 : (vcnt_reg == (vdiv_c >> 1)) ? 1'b0 : vout_reg;
    end
  end
  assign feedback_prescaler_clk = vdiv_sel ? vout_reg : clk_in.dist_clk; // RULE8

  // buffered output divider 1..8 with per-output bypass
  wire [3:0] odiv_c = (odiv < `ODIV_MIN) ? `ODIV_MIN : (odiv > `ODIV_MAX) ? `ODIV_MAX : odiv;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ocnt_reg <= 4'h0;
      oout_reg <= 1'b0;
    end else if (clk_in.osc_clk) begin
      ocnt_reg <= (ocnt_reg >= odiv_c - 4'h1) ? 4'h0 : ocnt_reg + 4'h1; // RULE9
      oout_reg <= (odiv_c == 4'h1) ? ~oout_reg : (ocnt_reg == 4'h0);
    end
  end
  // held low during sync; not aligned with distribution outputs
  for (genvar o = 0; o < NOSCOUT; o++) begin : g_osc
    assign buffered_osc_output[o] = sync_act ? 1'b0 :
                                    (obypass[o] ? clk_in.osc_clk : oout_reg); // RULE10 RULE12
  end

  // reference path
  //   automatic: first input not lost,
  //   in order a, c, b
  //   b is skipped while reused
  //   manual: register or select pins,
  //   higher pin wins
  //   b while reused falls back to a
  //   choice is registered once so the
  //   mux never sees a half-changed code
  //   only dual mode feeds first loop

  // reference selection, pre-divide and loop routing
  wire [1:0] auto_sel = !ref_los[0] ? 2'h0 : (!ref_los[2] || refb_reuse) ? 2'h2 : 2'h1;
  wire [1:0] pin_sel  = status_select_pin_in[2] ? 2'h2 : status_select_pin_in[1] ? 2'h1 : 2'h0;
  wire [1:0] man_sel  = pin_sel_en ? pin_sel : ref_man; // RULE16
  wire [1:0] sel_raw  = ref_auto ? auto_sel : man_sel; // RULE14
  wire [1:0] sel_fix  = (refb_reuse && sel_raw == 2'h1) ? 2'h0 : sel_raw; // RULE17
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ref_sel_reg <= 2'h0;
    else
      ref_sel_reg <= (sel_fix == 2'h3) ? 2'h0 : sel_fix;
  end
  // per-input pre-divider of 1,2,4 or 8, a two-bit power code
  for (genvar r = 0; r < 3; r++) begin : g_pre
    wire [1:0] pcode = ref_ctrl_reg[8 + 2*r +: 2]; // RULE23
    wire [3:0] plim  = 4'h1 << pcode;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pcnt_reg[r] <= 4'h0;
        pout_reg[r] <= 1'b0;
      end else if (ref_in[r]) begin
        pcnt_reg[r] <= (pcnt_reg[r] == plim - 4'h1) ? 4'h0 : pcnt_reg[r] + 4'h1; // RULE15
        pout_reg[r] <= (pcode == 2'h0) ? 1'b1 : (pcnt_reg[r] == 4'h0);
      end else if (pcode == 2'h0) begin
        pout_reg[r] <= 1'b0;
      end
    end
  end
  assign ref_to_first_loop   = (mode_reg == MODE_DUAL) ? pout_reg[ref_sel_reg] : 1'b0;
  assign first_loop_pd       = (mode_reg != MODE_DUAL); // RULE18
  assign second_loop_ref_sel = (mode_reg == MODE_SINGLE) | crystal_en; // RULE18 RULE22

  // group source tick: distribution, oscillator port, or second reference
  wire dist_src = (mode_reg == MODE_DIST) ? ref_in[1] : dist_tick; // RULE19

  // group operation, one per pair
  //   source: distribution tick, second
  //   reference in distribution mode, or
  //   oscillator port for the last two
  //   counter runs 0 .. dv-1 on ticks
  //   output high for the first half,
  //   exact for even divides, within a
  //   tick for odd ones
  //   half-step widens the high part of
  //   an odd divide by one tick
  //   divide of one toggles every tick
  //   26 or more selects extended range
  //   written delay waits in the config
  //   word; sync release copies it and
  //   loads the hold counter
  //   while holding, divider stands and
  //   output stays low
  //   fixed use: one delay, one sync
  //   absolute use: new delay, then sync
  //   relative use: add to the delay,
  //   then sync
  //   exempt and oscillator groups ignore
  //   the release; exempt ones keep their
  //   phase, others stand while sync is low
  //   divide 0 acts as 1, above is clamped
  //   delay clamped to the mode's range
  //   both pair pins read one flop

  // per-group divider, delay and sync handling
  for (genvar g = 0; g < NGROUPS; g++) begin : g_grp
    // source select
    wire sel_osc   = cfg_reg[g].osc_src & (g >= NGROUPS - 2); // RULE11
    wire tick      = sel_osc ? clk_in.osc_clk : dist_src;

    // divide clamp and delay range
    wire [10:0] dv = (cfg_reg[g].div == 11'h0) ? 11'h1 :
                     (cfg_reg[g].div > `GDIV_MAX) ? `GDIV_MAX : cfg_reg[g].div; // RULE1
    wire ext_mode  = (dv >= `EXT_THRESH); // RULE2
    wire [9:0] dmin = ext_mode ? `EXT_DLY_MIN : `NORM_DLY_MIN;
    wire [9:0] dmax = ext_mode ? `EXT_DLY_MAX : `NORM_DLY_MAX;

    // coarse delay clamp
    wire [9:0] dcl  = (cfg_reg[g].delay < dmin) ? dmin :
                      (cfg_reg[g].delay > dmax) ? dmax : cfg_reg[g].delay; // RULE3

    // output phase within the period
    wire hs_ok     = cfg_reg[g].half_step & (dv > 11'h1); // RULE4
    wire hi_half   = (cnt_reg[g] < (dv >> 1)) | (dv[0] & (cnt_reg[g] == (dv >> 1)) & hs_ok);

    // sync and write strobes
    wire resync    = sync_rel & ~cfg_reg[g].no_sync & ~sel_osc; // RULE13 RULE24
    wire wsel      = wr_acc & grp_ok & (gidx == 4'(g));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_reg[g]     <= '{fine_en: 1'b0, fine: 5'h0, osc_src: 1'b0, no_sync: 1'b0,
                            half_step: 1'b0, delay: `GDLY_RST, div: `GDIV_RST};
        dly_act_reg[g] <= `GDLY_RST;
        cnt_reg[g]     <= 11'h0;
        hold_reg[g]    <= 11'h0;
        gout_reg[g]    <= 1'b0;
      end else begin
        if (wsel)
          cfg_reg[g] <= group_cfg_t'(pwdata[29:0]); // RULE6
        if (resync) begin
          dly_act_reg[g] <= dcl; // RULE5
          hold_reg[g]    <= {1'b0, dcl}; // RULE24
          cnt_reg[g]     <= 11'h0;
          gout_reg[g]    <= 1'b0;
        end else if (sync_act && !cfg_reg[g].no_sync) begin
          gout_reg[g] <= 1'b0; // RULE12
        end else if (tick) begin
          if (hold_reg[g] != 11'h0) begin
            hold_reg[g] <= hold_reg[g] - 11'h1; // RULE3
          end else begin
            cnt_reg[g]  <= (cnt_reg[g] >= dv - 11'h1) ? 11'h0 : cnt_reg[g] + 11'h1;
            gout_reg[g] <= (dv == 11'h1) ? ~gout_reg[g] : hi_half; // RULE1
          end
        end
      end
    end

    // pair outputs share the group flop
    assign clk_out[2*g]     = gout_reg[g]; // RULE20
    assign clk_out[2*g + 1] = gout_reg[g]; // RULE20

    // fine delay code clamp and enable
    assign fine_delay_code[g] = (cfg_reg[g].fine > `FINE_MAX) ? `FINE_MAX : cfg_reg[g].fine; // RULE21
    assign fine_delay_en[g]   = cfg_reg[g].fine_en; // RULE21
  end

endmodule

// file: test/clock_divide_delay_properties.sv
// Purpose: concurrent checks on the distribution block ports
// Assumes: one pclk domain, presetn active low
// Notes:   bound from the bench top file
module clock_divide_delay_properties
  import clock_divide_delay_pkg::*;
#(
  parameter int NGROUPS = 6
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire clk_in_t              clk_in,
  input wire logic [2*NGROUPS-1:0] clk_out,
  input wire logic                 buffered_osc_output,
  input wire logic                 ref_to_first_loop,
  input wire logic                 first_loop_pd,
  input wire logic [4:0]           fine_delay_code [NGROUPS]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NGROUPS-1:0] pair_ok;
  logic               fine_ok;
  logic               mapped;
  // pair compare, fine code range and address decode
  always_comb begin
    fine_ok = 1'b1;
    mapped = paddr < 12'h018 || (paddr >= 12'h040 && paddr <= 12'h04C);
    for (int g = 0; g < NGROUPS; g++) begin
      pair_ok[g] = clk_out[2*g] == clk_out[2*g+1];
      if (fine_delay_code[g] > 5'h13) fine_ok = 1'b0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && paddr[1:0] == 2'h0;
  endsequence
  sequence s_bad_read;
    psel && penable && !pwrite && paddr[1:0] == 2'h0 && !mapped;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_slverr_map: assert property (s_access |-> pslverr == !mapped) else $error("pslverr wrong");
  a_bad_read_zero: assert property (s_bad_read |=> prdata == 32'h0) else $error("bad read data");
  a_prdata_hold: assert property (!(psel && penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved without a read");
  a_pair_same: assert property (&pair_ok) else $error("pair outputs differ");
  a_osc_sync_low: assert property (!clk_in.sync_n |-> !buffered_osc_output)
    else $error("osc output high in sync");
  a_loop_pd_ref: assert property (first_loop_pd |-> !ref_to_first_loop)
    else $error("reference passed while loop down");
  a_fine_range: assert property (fine_ok) else $error("fine code above 19");
endmodule

// file: test/clk_source_model.sv
// Purpose: source model feeding the tick inputs of the distribution block
// Assumes: distribution path ticks every pclk cycle
// Notes:   sync request from the bench becomes an active low level
module clk_source_model
  import clock_divide_delay_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sync_req,
  output clk_in_t         clk_in,
  output logic      [2:0] ref_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase_reg;
  // free running phase for oscillator and reference ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase_reg <= 3'h0;
    else phase_reg <= phase_reg + 3'h1;
  end
  assign clk_in.dist_clk = 1'b1;
  assign clk_in.osc_clk = phase_reg[0];
  assign clk_in.sync_n = !sync_req;
  assign ref_in = phase_reg;
endmodule

// file: test/clock_divide_delay_distribution_tb_top.sv
// Purpose: self-checking bench for the distribution block
// Assumes: APB zero wait, ticks from the source model
// Notes:   random group settings from a fixed seed
module clock_divide_delay_distribution_tb_top
  import clock_divide_delay_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sync_req = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, osc_out, ref1, pd, sel2, fbclk;
  logic [2:0] ref_in, ref_los = 0, pins = 0;
  logic [11:0] clk_out;
  logic [4:0] fcode [6];
  logic [5:0] fen;
  clk_in_t clk_in;
  group_cfg_t cfg;
  int seed, n_mismatch, cmp_count, cnt, dv;
  int dtab[4] = '{2, 5, 30, 2};
  clk_source_model src (.pclk(pclk), .presetn(presetn), .sync_req(sync_req),
    .clk_in(clk_in), .ref_in(ref_in));
  clock_divide_delay_distribution DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clk_in(clk_in), .ref_in(ref_in), .ref_los(ref_los),
    .status_select_pin_in(pins), .clk_out(clk_out), .buffered_osc_output(osc_out),
    .ref_to_first_loop(ref1), .first_loop_pd(pd), .second_loop_ref_sel(sel2),
    .feedback_prescaler_clk(fbclk), .fine_delay_code(fcode), .fine_delay_en(fen));
  always #25 pclk = ~pclk;
  // verdict and end of run
  task end_sim();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one APB transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    rd = prdata;
  endtask
  function automatic logic near(input int seen, input int div);
    return (seen - 240 / div) <= 1 && (240 / div - seen) <= 1;
  endfunction
  // rising edges of one output over n cycles
  task count_rises(input int n, input int b);
    logic last;
    cnt = 0;
    last = clk_out[b];
    repeat (n) begin
      @(negedge pclk);
      if (clk_out[b] && !last) cnt++;
      last = clk_out[b];
    end
  endtask
  // main sequence
  initial begin
    seed = 45849;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h000, 0); check(rd, 32'h0000_2801);
    apb(0, 12'h040, 0); check(rd, 32'h0000_0012);
    apb(0, 12'h044, 0); check(rd, 32'h0000_0001);
    apb(1, 12'h050, 32'hFFFF_FFFF); check({31'h0, er}, 32'h1);
    apb(0, 12'h020, 0); check(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      cfg = group_cfg_t'(30'($random(seed)));
      cfg.osc_src = 1'b0;
      cfg.div = 11'(1 + {$random(seed)} % 1045);
      cfg.delay = 10'(4 + {$random(seed)} % 519);
      cfg.fine = 5'({$random(seed)} % 20);
      apb(1, 12'(4 * i), {2'h0, cfg});
      apb(0, 12'(4 * i), 0); check(rd, {2'h0, cfg});
      check(fcode[i], cfg.fine);
      check(fen[i], cfg.fine_en);
    end
    apb(1, 12'h008, 32'h3F00_0004); check(fcode[2], 5'h13);
    foreach (dtab[k]) begin
      apb(1, 12'h048, 32'(k == 3 ? 1 : 2 * k + 2)); // mode 2, 4, 6 (ignored), 1
      apb(0, 12'h048, 0); check(rd, k == 3 ? 32'h1 : (k == 0 ? 32'h2 : 32'h4));
      check(pd, k != 3);
      if (k == 0) check(sel2, 1'b1);
    end
    apb(1, 12'h044, 32'h0000_0028); check(sel2, 1'b1);
    for (int k = 0; k < 3; k++) begin
      pins <= 3'(1 << k) | (k == 2 ? 3'h2 : 3'h0);
      apb(0, 12'h04C, 0); check(rd & 32'h3, k);
    end
    apb(1, 12'h044, 32'h0000_0001);
    ref_los <= 3'h1;
    apb(0, 12'h04C, 0); check(rd & 32'h3, 32'h2);
    ref_los <= 3'h5;
    apb(0, 12'h04C, 0); check(rd & 32'h3, 32'h1);
    apb(1, 12'h040, 32'h0000_0112);
    repeat (4) begin
      @(negedge pclk); check(osc_out, clk_in.osc_clk);
    end
    @(posedge pclk);
    apb(1, 12'h004, 32'h0040_2802);
    dtab[3] = 2 + {$random(seed)} % 47;
    foreach (dtab[k]) begin
      dv = dtab[k];
      apb(1, 12'h000, 32'(dv) | 32'h0000_2800);
      sync_req <= 1'b1;
      count_rises(8, 2); check(cnt >= 2, 1'b1);
      check(clk_out[1:0], 2'h0);
      @(posedge pclk);
      sync_req <= 1'b0;
      repeat (20) @(posedge pclk);
      count_rises(240, 0); check(near(cnt, dv), 1'b1);
      @(posedge pclk);
    end
    end_sim();
  end
  // watchdog against a hang
  initial begin
    #(50 * 40000);
    n_mismatch++;
    end_sim();
  end
endmodule
bind clock_divide_delay_distribution clock_divide_delay_properties #(.NGROUPS(NGROUPS)) props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_in(clk_in),
  .clk_out(clk_out), .buffered_osc_output(buffered_osc_output),
  .ref_to_first_loop(ref_to_first_loop), .first_loop_pd(first_loop_pd),
  .fine_delay_code(fine_delay_code));
